// ### verilog/sbs_pkg.sv
// ----------------------------------------------------------------
// Overview of operation
// - array of 65,536 words, 18 bits, 16-bit address split upper and low
// - address, data and all controls, output enable included, registered on rising clock
// - write starts on sampling edge and completes with no further strobe
// - two-bit burst counter drives the two low address bits, bursts up to four
// - counter loads from external low bits at burst start, steps per further word
// - upper fourteen address bits hold as captured during the whole burst
// - lower strobe writes low 9-bit byte, upper strobe writes high 9-bit byte
// - enabled processor strobe loads address, starts read, abandons prior burst
// - processor strobe ignored unless chip enable low on same edge
// - controller strobe starts write burst if any byte strobe low, else read
// - chip enable high with controller strobe low deselects, pins float
// - controller burst captures address, data, enable on the strobe edge
// - after first cycle, byte strobes decide read or write, enable ignored
// - burst step low advances counter, data on that edge stored at new address
// - all strobes and burst step high repeats current address, wait state
// - read data through output register, one clock after address load or step
// - output enable registered on rising clock; drives only during reads, else pins float
// - processor-started burst ignores byte strobes in first cycle, reads
// ----------------------------------------------------------------
package sbs_pkg;
   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 18;
   localparam int BYTE_W   = 9;
   localparam int LOW_W    = 2;
   localparam int UPPER_W  = ADDR_W - LOW_W;
   localparam int DEPTH    = 65536;
   localparam logic [LOW_W-1:0] STEP_ONE = 2'h1;
   localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;

   // bus cycle kind held between edges
   typedef enum logic [1:0]
   {
      SBS_IDLE  = 2'b00,
      SBS_READ  = 2'b01,
      SBS_WRITE = 2'b10
   } sbs_mode_e;
endpackage

// ### verilog/sbs_mem.sv
// ----------------------------------------------------------------
// byte-writable array with registered read port
// ----------------------------------------------------------------
module sbs_mem
#(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 18,
   parameter int BYTE_W = 9
)
(
   input  wire logic              CLK,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              we_lo,
   input  wire logic              we_hi,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              re,
   output      logic [DATA_W-1:0] rdata
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // array contents have no reset, as in the real part
   always_ff @(posedge CLK)
   begin
      if (we_lo)
      begin
         mem[addr][BYTE_W-1:0] <= wdata[BYTE_W-1:0];
      end
      if (we_hi)
      begin
         mem[addr][DATA_W-1:BYTE_W] <= wdata[DATA_W-1:BYTE_W];
      end
      if (re)
      begin
         rdata <= mem[addr];
      end
   end
endmodule // sbs_mem

// ### verilog/sbs_port.sv
// ----------------------------------------------------------------
// synchronous burst sram bus port
// ----------------------------------------------------------------
module sbs_port
(
   input  wire logic                       CLK,
   input  wire logic                       RSTN,
   input  wire logic [sbs_pkg::UPPER_W-1:0] UPPER_WORD_ADDR,
   input  wire logic [sbs_pkg::LOW_W-1:0]  LOW_WORD_ADDR,
   input  wire logic                       CHIP_ON_N,
   input  wire logic                       PROC_ADDR_STROBE_N,
   input  wire logic                       CTRL_ADDR_STROBE_N,
   input  wire logic                       BURST_STEP_N,
   input  wire logic                       UPPER_BYTE_WRITE_N,
   input  wire logic                       LOWER_BYTE_WRITE_N,
   input  wire logic                       OUT_DRIVE_N,
   input  wire logic [sbs_pkg::DATA_W-1:0] DATA_IO_I,
   output      logic [sbs_pkg::DATA_W-1:0] DATA_IO_O,
   output      logic [sbs_pkg::DATA_W-1:0] DATA_IO_OE
);
   // ----------------------------------------------------------------
   // input registers
   // ----------------------------------------------------------------
   // bus inputs come from same-clock master logic, so no synchroniser
   logic [sbs_pkg::UPPER_W-1:0] up_r,  up_nxt;
   logic [sbs_pkg::LOW_W-1:0]   cnt_r, cnt_nxt;
   logic [sbs_pkg::DATA_W-1:0]  wd_r,  wd_nxt;
   logic                        wlo_r, wlo_nxt;
   logic                        whi_r, whi_nxt;
   logic                        acc_r, acc_nxt;
   sbs_pkg::sbs_mode_e          mode_r, mode_nxt;
   logic                        rd_ok_r, rd_ok_nxt;
   logic                        drv_r, drv_nxt;

   logic                        p_start;
   logic                        c_start;
   logic                        desel;
   logic                        cont;
   logic                        any_w;
   logic [sbs_pkg::DATA_W-1:0]  rdata;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   always_comb
   begin
      p_start = !CHIP_ON_N && !PROC_ADDR_STROBE_N;
      c_start = !CHIP_ON_N && PROC_ADDR_STROBE_N && !CTRL_ADDR_STROBE_N;
      desel   = CHIP_ON_N && !CTRL_ADDR_STROBE_N;
      // a processor strobe without chip enable is ignored, so it still continues
      cont    = (PROC_ADDR_STROBE_N || CHIP_ON_N) && CTRL_ADDR_STROBE_N;
      any_w   = !UPPER_BYTE_WRITE_N || !LOWER_BYTE_WRITE_N;
   end

   // next state of address, data and cycle control
   always_comb
   begin
      up_nxt    = up_r;
      cnt_nxt   = cnt_r;
      wd_nxt    = DATA_IO_I;
      wlo_nxt   = 1'b0;
      whi_nxt   = 1'b0;
      acc_nxt   = 1'b0;
      mode_nxt  = mode_r;
      if (p_start)
      begin
         up_nxt   = UPPER_WORD_ADDR;
         cnt_nxt  = LOW_WORD_ADDR;
         acc_nxt  = 1'b1;
         mode_nxt = sbs_pkg::SBS_READ;
      end
      else if (c_start)
      begin
         up_nxt  = UPPER_WORD_ADDR;
         cnt_nxt = LOW_WORD_ADDR;
         acc_nxt = 1'b1;
         if (any_w)
         begin
            wlo_nxt  = !LOWER_BYTE_WRITE_N;
            whi_nxt  = !UPPER_BYTE_WRITE_N;
            mode_nxt = sbs_pkg::SBS_WRITE;
         end
         else
         begin
            mode_nxt = sbs_pkg::SBS_READ;
         end
      end
      else if (desel)
      begin
         mode_nxt = sbs_pkg::SBS_IDLE;
      end
      else if (cont && mode_r != sbs_pkg::SBS_IDLE)
      begin
         // upper bits untouched, only the counter may move
         if (!BURST_STEP_N)
         begin
            cnt_nxt = cnt_r + sbs_pkg::STEP_ONE;
         end
         acc_nxt = 1'b1;
         if (any_w)
         begin
            wlo_nxt  = !LOWER_BYTE_WRITE_N;
            whi_nxt  = !UPPER_BYTE_WRITE_N;
            mode_nxt = sbs_pkg::SBS_WRITE;
         end
         else
         begin
            mode_nxt = sbs_pkg::SBS_READ;
         end
      end
   end

   // registers; write lands one cycle after sampling, self timed
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         up_r   <= '0;
         cnt_r  <= '0;
         wd_r   <= sbs_pkg::DATA_RST;
         wlo_r  <= 1'b0;
         whi_r  <= 1'b0;
         acc_r  <= 1'b0;
         mode_r <= sbs_pkg::SBS_IDLE;
      end
      else
      begin
         up_r   <= up_nxt;
         cnt_r  <= cnt_nxt;
         wd_r   <= wd_nxt;
         wlo_r  <= wlo_nxt;
         whi_r  <= whi_nxt;
         acc_r  <= acc_nxt;
         mode_r <= mode_nxt;
      end
   end

   // ----------------------------------------------------------------
   // array
   // ----------------------------------------------------------------
   sbs_mem
   #(
      .ADDR_W (sbs_pkg::ADDR_W),
      .DATA_W (sbs_pkg::DATA_W),
      .BYTE_W (sbs_pkg::BYTE_W)
   )
   u_mem
   (
      .CLK   (CLK),
      .addr  ({up_r, cnt_r}),
      .we_lo (wlo_r),
      .we_hi (whi_r),
      .wdata (wd_r),
      .re    (acc_r && mode_r == sbs_pkg::SBS_READ),
      .rdata (rdata)
   );

   // ----------------------------------------------------------------
   // output drive
   // ----------------------------------------------------------------
   // read valid flag is set on the same edge that loads the array read register
   always_comb
   begin
      rd_ok_nxt = acc_r && mode_r == sbs_pkg::SBS_READ;
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         rd_ok_r <= 1'b0;
      end
      else
      begin
         rd_ok_r <= rd_ok_nxt;
      end
   end

   // enable is registered so outputs stay flop driven; costs one clock of
   // output enable latency versus the asynchronous pin of the real part
   always_comb
   begin
      drv_nxt = rd_ok_nxt && !OUT_DRIVE_N;
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         drv_r <= 1'b0;
      end
      else
      begin
         drv_r <= drv_nxt;
      end
   end

   always_comb
   begin
      DATA_IO_O  = rdata;
      DATA_IO_OE = {sbs_pkg::DATA_W{drv_r}};
   end
endmodule // sbs_port

// ### tb/sbs_master.sv
// ------------
// bus master model
// ------------
module sbs_master
(
   input  wire logic        CLK,
   output      logic [6:0]  CTL,
   output      logic [15:0] ADDR,
   output      logic [17:0] WD
);
   timeunit 1ns / 1ps;
   // bus idle from time zero
   initial {CTL, ADDR, WD} = {7'h7F, 16'h0000, 18'h00000};
   // one cycle from the falling edge; ctl is chip proc ctrl step upper lower oe
   task automatic cyc(input logic [6:0] c, input logic [15:0] a, input logic [17:0] d);
      @(negedge CLK);
      CTL  = c;
      ADDR = a;
      WD   = (c[2:1] != 2'h3) ? d : ~WD; // released line toggles, stale data never matches
   endtask
endmodule // sbs_master

// ### tb/sbs_port_sva.sv
// ------------
// burst port checker
// ------------
module sbs_port_chk
(
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        CHIP_ON_N,
   input wire logic        PROC_ADDR_STROBE_N,
   input wire logic        CTRL_ADDR_STROBE_N,
   input wire logic        BURST_STEP_N,
   input wire logic        UPPER_BYTE_WRITE_N,
   input wire logic        LOWER_BYTE_WRITE_N,
   input wire logic        OUT_DRIVE_N,
   input wire logic [17:0] DATA_IO_O,
   input wire logic [17:0] DATA_IO_OE
);
   timeunit 1ns / 1ps;
   // decoded starts; an ungated processor strobe counts as continue
   wire logic pst  = !CHIP_ON_N && !PROC_ADDR_STROBE_N;
   wire logic cst  = !CHIP_ON_N && PROC_ADDR_STROBE_N && !CTRL_ADDR_STROBE_N;
   wire logic bw   = !UPPER_BYTE_WRITE_N || !LOWER_BYTE_WRITE_N;
   wire logic cont = (PROC_ADDR_STROBE_N || CHIP_ON_N) && CTRL_ADDR_STROBE_N;
   // pin enable is seen two edges after the start strobe, together with the read data
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RSTN);
   a_proc_rd_on: assert property (pst ##1 !OUT_DRIVE_N |=> DATA_IO_OE == '1)
      else $error("read not driven");
   a_proc_rd_off: assert property (pst ##1 OUT_DRIVE_N |=> DATA_IO_OE == '0)
      else $error("pins driven while off");
   a_ctrl_rd_on: assert property (cst && !bw ##1 !OUT_DRIVE_N |=> DATA_IO_OE == '1)
      else $error("ctrl read not driven");
   a_ctrl_wr_off: assert property (cst && bw |-> ##2 DATA_IO_OE == '0)
      else $error("write start drove pins");
   a_desel_float: assert property (CHIP_ON_N && !CTRL_ADDR_STROBE_N |-> ##2 DATA_IO_OE == '0)
      else $error("deselect drove pins");
   a_cont_wr_off: assert property (cont && bw |-> ##2 DATA_IO_OE == '0)
      else $error("burst write drove pins");
   a_hold_stable: assert property ((pst || cst && !bw) ##1 cont && BURST_STEP_N && !bw |=> ##1 $stable(DATA_IO_O))
      else $error("wait state moved data");
   a_rst_quiet: assert property ($rose(RSTN) |-> DATA_IO_OE == '0 ##1 DATA_IO_OE == '0)
      else $error("pins driven after reset");
endmodule // sbs_port_chk

bind sbs_port sbs_port_chk u_chk (.*);

// ### tb/tb.sv
// ------------
// burst port bench
// ------------
module tb;
   timeunit 1ns / 1ps;
   // cycle codes: chip proc ctrl step upper lower oe, all active low
   localparam logic [6:0] PST = 7'h1E, PWR = 7'h18, CRD = 7'h2E, STR = 7'h76, STRH = 7'h77;
   localparam logic [6:0] STRP = 7'h56, HLD = 7'h7E, DSL = 7'h6E;
   localparam logic [6:0] CWR = 7'h29, CWU = 7'h2B, CWL = 7'h2D, STW = 7'h71, HLW = 7'h7F;
   localparam logic [17:0] D0 = 18'h12345, D1 = 18'h2ABCD, D2 = 18'h0F0F0, D3 = 18'h3C3C3;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [6:0]  ctl;
   logic [15:0] adr;
   logic [17:0] wd;
   logic [17:0] dq_o;
   logic [17:0] dq_oe;
   int          err_total = 0;
   int          n_checks = 0;
   // free-running clock
   always #5 clk = ~clk;
   // master model and port; data pins resolved from the port enable
   sbs_master m (.CLK(clk), .CTL(ctl), .ADDR(adr), .WD(wd));
   sbs_port dut
   (
      .CLK(clk), .RSTN(rstn), .UPPER_WORD_ADDR(adr[15:2]), .LOW_WORD_ADDR(adr[1:0]), .CHIP_ON_N(ctl[6]),
      .PROC_ADDR_STROBE_N(ctl[5]), .CTRL_ADDR_STROBE_N(ctl[4]), .BURST_STEP_N(ctl[3]),
      .UPPER_BYTE_WRITE_N(ctl[2]), .LOWER_BYTE_WRITE_N(ctl[1]), .OUT_DRIVE_N(ctl[0]),
      .DATA_IO_I((dq_oe & dq_o) | (~dq_oe & wd)), .DATA_IO_O(dq_o), .DATA_IO_OE(dq_oe)
   );
   // data compare
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // pin enable compare
   task automatic chk_oe(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: enable %h want %h", $time, got, exp);
      end
   endtask
   // start, three steps, then pins off so a later write meets no contention
   task automatic rdb(input logic [6:0] st, input logic [15:0] a, input logic [6:0] stp, input logic [17:0] e [4]);
      for (int i = 0; i < 7; i++)
      begin
         m.cyc(i == 0 ? st : (i < 4 ? stp : HLW), a, 18'h00000);
         if (i >= 2 && i < 6)
         begin
            chk(dq_o, e[i-2]);
            chk_oe(dq_oe, {18{i < 5 && !stp[0]}});
         end
      end
   endtask
   // wrapping write burst with a wait state, read back from two starts
   task automatic t_burst;
      m.cyc(CWR, 16'hA97, D0);
      m.cyc(STW, 16'hA97, D1);
      m.cyc(HLW, 16'hA97, D1);
      m.cyc(STW, 16'hA97, D2);
      m.cyc(STW, 16'hA97, D3);
      rdb(PST, 16'hA97, STRP, '{D0, D1, D2, D3});
      rdb(PWR, 16'hA94, STRH, '{D1, D2, D3, D0});
   endtask
   // single-byte writes, back to back starts
   task automatic t_bytes;
      m.cyc(CWU, 16'hA94, 18'h00000);
      m.cyc(CWL, 16'hA95, 18'h3FFFF);
      rdb(CRD, 16'hA95, STR, '{{D2[17:9], 9'h1FF}, D3, D0, {9'h0, D1[8:0]}});
   endtask
   // after deselect, continue writes must be refused
   task automatic t_desel;
      m.cyc(DSL, 16'hA96, 18'h00000);
      m.cyc(STW, 16'hA96, 18'h00000);
      m.cyc(STW, 16'hA96, 18'h00000);
      rdb(CRD, 16'hA96, HLD, '{D3, D3, D3, D3});
   endtask
   // verdict
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // reset for six edges, then scenarios
   initial
   begin
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      t_burst;
      t_bytes;
      t_desel;
      report_and_stop;
   end
   // watchdog, far beyond the ~44 cycles needed
   initial
   begin
      #5000;
      err_total++;
      report_and_stop;
   end
endmodule // tb
